// File: hdl/lers_pkg.sv
// lers_pkg: constants and types for the link error recovery sequencer
// assumes a single 125 MHz port clock shared by every user of this package
package lers_pkg;

	// ----------------------------------------------------------------
	// buffers and counters
	// ----------------------------------------------------------------
	localparam int unsigned NBUF       = 8;
	localparam int unsigned PTR_W      = 3;
	localparam int unsigned SEQ_W      = 8;
	localparam logic [7:0]  SEQ_MASK_N = 8'h03;
	localparam logic [7:0]  SEQ_MASK_X = 8'hFF;
	localparam logic [2:0]  PTR_RST    = 3'h0;
	localparam logic [7:0]  SEQ_RST    = 8'h00;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_PS = 8000;
	localparam int unsigned TMO_TIME_MS   = 5;
	localparam int unsigned TMO_CYC       = TMO_TIME_MS * (1000000000 / CLK_PERIOD_PS);

	// ----------------------------------------------------------------
	// states and failure codes
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_READY,
		ST_CHECK,
		ST_WAIT_LR,
		ST_ADJUST,
		ST_DISCARD,
		ST_DISABLED,
		ST_ENABLED,
		ST_FAILED
	} lers_state_t;

	typedef enum logic [1:0] {
		FC_NONE,
		FC_LINK_RESET,
		FC_DISABLED_TMO,
		FC_READY_TMO
	} lers_fail_t;

	localparam logic [1:0] FC_INVALID_RETRY = 2'h0;

endpackage

// File: hdl/lers_timer.sv
// lers_timer: restartable timeout counter, one pulse when the count elapses
// assumes restart is a one-cycle pulse from logic on the same clock
`timescale 1ns/10ps
`default_nettype none
module lers_timer #(
	parameter int unsigned CYCLES = 16
) (
	input  wire logic clk,     // port clock
	input  wire logic rst,     // synchronous reset
	input  wire logic restart, // clear and start counting
	input  wire logic run,     // count while high
	output logic      expired  // one-cycle pulse at timeout
);
	logic [31:0] cnt_reg;

	always_ff @(posedge clk) begin
		if (rst || restart || !run) begin
			cnt_reg <= 32'h0000_0000;
			expired <= 1'b0;
		end else begin
			if (cnt_reg != CYCLES)
				cnt_reg <= cnt_reg + 32'h0000_0001;
			expired <= (cnt_reg == CYCLES - 1);
		end
	end
endmodule
`default_nettype wire

// File: hdl/lers_core.sv
// lers_core: link error recovery sequencer for one serial port
// assumes link receive and transmit logic on REF_CLK give one-cycle event pulses
`timescale 1ns/10ps
`default_nettype none
module lers_core #(
	parameter int unsigned TMO_CYCLES = lers_pkg::TMO_CYC
) (
	input  wire logic       REF_CLK,           // port clock
	input  wire logic       RST,               // synchronous reset, high
	input  wire logic       EXT_MODE,          // extended sequence range
	input  wire logic       TX_FRAME_START,    // new frame being sent
	input  wire logic       TX_BUSY,           // transmitter sending a frame
	input  wire logic       RX_GOOD_FRAME,     // frame with good crc received
	input  wire logic       RX_ACK,            // acknowledge pair received
	input  wire logic       RX_CODE_VIOL,      // code violation seen
	input  wire logic       RX_LINK_RESET,     // peer link reset received
	input  wire logic [7:0] RX_REMOTE_RSC,     // peer receive counter in it
	input  wire logic       RX_DIS,            // disable characters seen
	input  wire logic       RX_FLAG,           // flag character seen
	output logic            FRAME_READY,       // new frames may start
	output logic            TX_ABORT,          // abort frame in flight
	output logic            TX_SEND_ACK,       // send acknowledge pair
	output logic            TX_SEND_LINK_RESET,// send link reset frame
	output logic [7:0]      LINK_STATUS,       // status byte for link reset
	output logic            TX_SEND_DIS,       // send disable characters
	output logic            TX_SEND_FLAG,      // send flag characters
	output logic            TX_RESEND,         // retransmit one buffer
	output logic [2:0]      TX_RESEND_PTR,     // buffer to retransmit
	output logic [2:0]      TX_BUF_PTR,        // transmit buffer pointer
	output logic [2:0]      RETRY_PTR,         // retry pointer
	output logic [7:0]      TX_SEQ,            // transmit sequence counter
	output logic [7:0]      RX_SEQ,            // receive sequence counter
	output logic            ERP_ACTIVE,        // recovery in progress
	output logic            ERP_DONE,          // recovery ended well
	output logic            ERP_FAIL,          // recovery ended in failure
	output logic [1:0]      FAIL_CODE          // cause of failure
);
	// ------------------------------------------------------------
	// state and events
	// ------------------------------------------------------------
	lers_pkg::lers_state_t state_reg;
	lers_pkg::lers_state_t state_last_reg;
	logic [2:0] tp_reg;
	logic [2:0] rp_reg;
	logic [2:0] resend_end_reg;
	logic [7:0] tsc_reg;
	logic [7:0] rsc_reg;
	logic [7:0] remote_rsc_reg;
	logic       lr_seen_reg;
	logic       gap_reg;
	logic [7:0] seq_mask;
	logic [2:0] q_cnt;
	logic [7:0] p_cnt;
	logic       retry_bad;
	logic       in_ready;
	logic       ev_send;
	logic       ev_resend;
	logic       ev_ack;
	logic       ev_rxgood;
	logic       tmo;
	logic       tmo_raw;
	logic       tmr_restart;
	logic       tmr_run;

	assign seq_mask    = EXT_MODE ? lers_pkg::SEQ_MASK_X : lers_pkg::SEQ_MASK_N;
	assign in_ready    = (state_reg == lers_pkg::ST_READY);
	assign ev_send     = in_ready && TX_FRAME_START && (tp_reg == resend_end_reg);
	assign ev_resend   = in_ready && (tp_reg != resend_end_reg) && !TX_BUSY && !gap_reg;
	assign ev_ack      = in_ready && RX_ACK && (rp_reg != tp_reg);
	assign ev_rxgood   = in_ready && RX_GOOD_FRAME;
	assign q_cnt       = tp_reg - rp_reg;
	assign p_cnt       = (tsc_reg - remote_rsc_reg) & seq_mask;
	assign retry_bad   = p_cnt > {5'h00, q_cnt};
	assign tmr_restart = (state_reg != state_last_reg);
	assign tmr_run     = (state_reg == lers_pkg::ST_WAIT_LR) || (state_reg == lers_pkg::ST_DISABLED)
		|| (state_reg == lers_pkg::ST_ENABLED);
	assign tmo         = tmo_raw && !tmr_restart; // drop a pulse left over from the state just left

	lers_timer #(
		.CYCLES (TMO_CYCLES)
	) u_tmr (
		.clk     (REF_CLK),
		.rst     (RST),
		.restart (tmr_restart),
		.run     (tmr_run),
		.expired (tmo_raw)
	);

	// ------------------------------------------------------------
	// pointers and sequence counters
	// ------------------------------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			tp_reg         <= lers_pkg::PTR_RST;
			rp_reg         <= lers_pkg::PTR_RST;
			resend_end_reg <= lers_pkg::PTR_RST;
			tsc_reg        <= lers_pkg::SEQ_RST;
			rsc_reg        <= lers_pkg::SEQ_RST;
			remote_rsc_reg <= lers_pkg::SEQ_RST;
			gap_reg        <= 1'b0;
		end else begin
			gap_reg <= ev_resend;
			if (RX_LINK_RESET)
				remote_rsc_reg <= RX_REMOTE_RSC;
			if (state_reg == lers_pkg::ST_DISABLED) begin
				tsc_reg <= lers_pkg::SEQ_RST;
				rsc_reg <= lers_pkg::SEQ_RST;
			end else begin
				if (ev_send || ev_resend)
					tsc_reg <= (tsc_reg + 8'h01) & seq_mask;
				if (ev_rxgood)
					rsc_reg <= (rsc_reg + 8'h01) & seq_mask;
			end
			if (ev_send) begin
				tp_reg         <= tp_reg + 3'h1;
				resend_end_reg <= resend_end_reg + 3'h1;
			end else if (ev_resend) begin
				tp_reg <= tp_reg + 3'h1;
			end else if (state_reg == lers_pkg::ST_ADJUST && !retry_bad) begin
				tp_reg <= tp_reg - p_cnt[2:0];
			end
			if (ev_ack)
				rp_reg <= rp_reg + 3'h1;
			else if (state_reg == lers_pkg::ST_DISCARD && rp_reg != tp_reg)
				rp_reg <= rp_reg + 3'h1;
		end
	end

	// ------------------------------------------------------------
	// recovery sequence
	// ------------------------------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			state_reg      <= lers_pkg::ST_READY;
			state_last_reg <= lers_pkg::ST_READY;
			lr_seen_reg    <= 1'b0;
			FAIL_CODE      <= lers_pkg::FC_NONE;
		end else begin
			state_last_reg <= state_reg;
			if (RX_LINK_RESET)
				lr_seen_reg <= 1'b1;
			case (state_reg)
				lers_pkg::ST_READY: begin
					if (RX_LINK_RESET || RX_CODE_VIOL)
						state_reg <= lers_pkg::ST_CHECK;
				end
				lers_pkg::ST_CHECK: begin
					if (!TX_BUSY)
						state_reg <= lers_pkg::ST_WAIT_LR;
				end
				lers_pkg::ST_WAIT_LR: begin
					if (lr_seen_reg || RX_LINK_RESET) begin
						state_reg <= lers_pkg::ST_ADJUST;
					end else if (tmo) begin
						state_reg <= lers_pkg::ST_FAILED;
						FAIL_CODE <= lers_pkg::FC_LINK_RESET;
					end
				end
				lers_pkg::ST_ADJUST: begin
					if (retry_bad) begin
						state_reg <= lers_pkg::ST_FAILED;
						FAIL_CODE <= lers_pkg::FC_INVALID_RETRY;
					end else begin
						state_reg <= lers_pkg::ST_DISCARD;
					end
				end
				lers_pkg::ST_DISCARD: begin
					if (rp_reg == tp_reg) begin
						state_reg   <= lers_pkg::ST_DISABLED;
						lr_seen_reg <= RX_LINK_RESET; // a link reset in this cycle still counts
					end
				end
				lers_pkg::ST_DISABLED: begin
					if (RX_DIS) begin
						state_reg <= lers_pkg::ST_ENABLED;
					end else if (tmo) begin
						state_reg <= lers_pkg::ST_FAILED;
						FAIL_CODE <= lers_pkg::FC_DISABLED_TMO;
					end
				end
				lers_pkg::ST_ENABLED: begin
					if (RX_FLAG) begin
						state_reg <= lers_pkg::ST_READY;
					end else if (tmo) begin
						state_reg <= lers_pkg::ST_FAILED;
						FAIL_CODE <= lers_pkg::FC_READY_TMO;
					end
				end
				lers_pkg::ST_FAILED: begin
					state_reg <= lers_pkg::ST_FAILED;
				end
				default: begin
					state_reg <= lers_pkg::ST_READY;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// registered outputs
	// ------------------------------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			FRAME_READY        <= 1'b0;
			TX_ABORT           <= 1'b0;
			TX_SEND_ACK        <= 1'b0;
			TX_SEND_LINK_RESET <= 1'b0;
			LINK_STATUS        <= 8'h00;
			TX_SEND_DIS        <= 1'b0;
			TX_SEND_FLAG       <= 1'b0;
			TX_RESEND          <= 1'b0;
			TX_RESEND_PTR      <= 3'h0;
			ERP_ACTIVE         <= 1'b0;
			ERP_DONE           <= 1'b0;
			ERP_FAIL           <= 1'b0;
		end else begin
			FRAME_READY        <= in_ready && (tp_reg == resend_end_reg);
			TX_ABORT           <= in_ready && RX_CODE_VIOL && TX_BUSY;
			TX_SEND_ACK        <= RX_LINK_RESET || ev_rxgood;
			TX_SEND_LINK_RESET <= (state_reg == lers_pkg::ST_CHECK) && !TX_BUSY;
			if ((state_reg == lers_pkg::ST_CHECK) && !TX_BUSY)
				LINK_STATUS <= rsc_reg;
			TX_SEND_DIS        <= (state_reg == lers_pkg::ST_DISABLED) || (state_reg == lers_pkg::ST_FAILED);
			TX_SEND_FLAG       <= (state_reg == lers_pkg::ST_ENABLED);
			TX_RESEND          <= ev_resend;
			TX_RESEND_PTR      <= tp_reg;
			ERP_ACTIVE         <= !in_ready && (state_reg != lers_pkg::ST_FAILED);
			ERP_DONE           <= (state_reg == lers_pkg::ST_ENABLED) && RX_FLAG;
			ERP_FAIL           <= (state_reg != lers_pkg::ST_FAILED) && (state_last_reg != lers_pkg::ST_FAILED)
				&& tmr_run && tmo && !((state_reg == lers_pkg::ST_WAIT_LR) && (lr_seen_reg || RX_LINK_RESET))
				&& !((state_reg == lers_pkg::ST_DISABLED) && RX_DIS) && !((state_reg == lers_pkg::ST_ENABLED) && RX_FLAG)
				|| (state_reg == lers_pkg::ST_ADJUST) && retry_bad;
		end
	end

	assign TX_BUF_PTR = tp_reg;
	assign RETRY_PTR  = rp_reg;
	assign TX_SEQ     = tsc_reg;
	assign RX_SEQ     = rsc_reg;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	AST_RESET_ZERO:
	assert property (@(posedge REF_CLK) $fell(RST) |-> (tp_reg == 3'h0 && rp_reg == 3'h0 && tsc_reg == 8'h00))
		else $error("counters not zero after reset");
	AST_SEND_BUMP:
	assert property (@(posedge REF_CLK) disable iff (RST) ev_send |=> tp_reg == $past(tp_reg) + 3'h1)
		else $error("buffer pointer did not advance on send");
	AST_GOOD_ACK:
	assert property (@(posedge REF_CLK) disable iff (RST) ev_rxgood |=> TX_SEND_ACK)
		else $error("no acknowledge after good frame");
	AST_VIOL_CHECK:
	assert property (@(posedge REF_CLK) disable iff (RST)
		in_ready && RX_CODE_VIOL && TX_BUSY |=> TX_ABORT && state_reg == lers_pkg::ST_CHECK)
		else $error("violation did not abort and enter check");
	AST_LR_AFTER_TX:
	assert property (@(posedge REF_CLK) disable iff (RST)
		state_reg == lers_pkg::ST_CHECK && TX_BUSY |=> !TX_SEND_LINK_RESET)
		else $error("link reset sent while transmitting");
	AST_LR_ACK:
	assert property (@(posedge REF_CLK) disable iff (RST) RX_LINK_RESET |=> TX_SEND_ACK)
		else $error("link reset not acknowledged");
	AST_DIS_CLEAR:
	assert property (@(posedge REF_CLK) disable iff (RST)
		state_reg == lers_pkg::ST_DISABLED |=> TX_SEND_DIS && tsc_reg == 8'h00 && rsc_reg == 8'h00)
		else $error("disabled state did not clear counters");
	AST_FLAG_READY:
	assert property (@(posedge REF_CLK) disable iff (RST)
		state_reg == lers_pkg::ST_ENABLED && RX_FLAG |=> in_ready ##1 !TX_SEND_FLAG)
		else $error("flag did not reach ready");
	AST_DIS_TMO:
	assert property (@(posedge REF_CLK) disable iff (RST)
		state_reg == lers_pkg::ST_DISABLED && tmo && !RX_DIS |=> state_reg == lers_pkg::ST_FAILED && ERP_FAIL)
		else $error("disabled timeout missed");
	AST_RDY_TMO:
	assert property (@(posedge REF_CLK) disable iff (RST)
		state_reg == lers_pkg::ST_ENABLED && tmo && !RX_FLAG |=> FAIL_CODE == lers_pkg::FC_READY_TMO)
		else $error("ready timeout missed");
endmodule
`default_nettype wire

// File: test/lers_peer.sv
// lers_peer: behavioural far-side port that runs the same link recovery
// assumes it shares the port clock and the reset with the sequencer
`timescale 1ns/10ps
`default_nettype none
module lers_peer (
	input  wire logic       clk,         // port clock
	input  wire logic       rst,         // sync reset
	input  wire logic [2:0] mode,        // 0 normal, 1-3 silent phase, 4 bad counter
	input  wire logic       drop_ack,    // lose acks
	input  wire logic [3:0] dly,         // reply latency
	input  wire logic       frame_start, // frame starts
	input  wire logic       tx_busy,     // frame on line
	input  wire logic       tx_abort,    // frame aborted
	input  wire logic       send_lr,     // link reset in
	input  wire logic       send_dis,    // disable chars in
	input  wire logic       send_flag,   // flag chars in
	output logic            rx_ack,      // ack pair
	output logic            rx_link_reset, // link reset out
	output logic [7:0]      rx_remote_rsc, // its counter
	output logic            rx_dis,      // disable chars
	output logic            rx_flag      // flag chars
);
	int   rx_seq_count, ph, wc;
	logic inflight, busy_d, s_fs, s_busy, s_ab, s_lr, s_dis, s_flag, s_drop;

	initial begin
		{rx_ack, rx_link_reset, rx_dis, rx_flag} = 4'h0;
		rx_remote_rsc = 8'h00;
	end

	// ----------------------------------------------------------------
	// sample at the edge, answer just after it
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		{s_fs, s_busy, s_ab, s_lr} = {frame_start, tx_busy, tx_abort, send_lr};
		{s_dis, s_flag, s_drop} = {send_dis, send_flag, drop_ack};
		#1;
		rx_ack = 1'b0;
		rx_link_reset = 1'b0;
		rx_remote_rsc = ~rx_remote_rsc; // not valid outside a link reset
		if (rst) begin
			rx_seq_count = 0;
			ph = 0;
			wc = 0;
			{inflight, busy_d, rx_dis, rx_flag} = 4'h0;
		end else begin
			if (s_fs)
				inflight = 1'b1;
			if (s_ab)
				inflight = 1'b0;
			if (busy_d && !s_busy && inflight) begin
				rx_seq_count++;
				inflight = 1'b0;
				rx_ack = !s_drop;
			end
			if (wc > 0)
				wc--;
			if (s_lr)
				rx_ack = 1'b1;
			case (ph)
				0: if (s_lr && mode != 3'h1) begin
					ph = 1;
					wc = dly;
				end
				1: if (wc == 0) begin
					rx_link_reset = 1'b1;
					rx_remote_rsc = 8'(rx_seq_count + ((mode == 3'h4) ? 3 : 0));
					rx_seq_count = 0;
					ph = 2;
				end
				2: begin
					rx_dis = (mode != 3'h2);
					if (s_dis) begin
						ph = 3;
						wc = dly + 2;
					end
				end
				3: if (wc == 0) begin
					rx_dis = 1'b0;
					rx_flag = (mode != 3'h3);
					ph = 4;
				end
				4: if (s_flag) begin
					ph = 5;
					wc = dly + 2;
				end
				default: if (wc == 0) begin
					rx_flag = 1'b0;
					ph = 0;
				end
			endcase
			busy_d = s_busy;
		end
	end
endmodule
`default_nettype wire

// File: test/test_lers_core.sv
// test_lers_core: self-checking bench for the link error recovery sequencer
// assumes lers_peer at the far side and a shortened timeout parameter
`timescale 1ns/10ps
`default_nettype none
module test_lers_core;
	localparam int TMO = 50;
	logic        ref_clk = 1'b0, rst = 1'b1, ext_mode = 1'b0, tx_frame_start = 1'b0;
	logic        tx_busy = 1'b0, rx_good_frame = 1'b0, rx_code_viol = 1'b0, drop_ack = 1'b0;
	logic [2:0]  mode = 3'h0;
	logic [3:0]  dly = 4'h1;
	logic        rx_ack, rx_link_reset, rx_dis, rx_flag, frame_ready, tx_abort, tx_send_ack;
	logic        tx_send_link_reset, tx_send_dis, tx_send_flag, tx_resend, erp_active, erp_done, erp_fail;
	logic [7:0]  rx_remote_rsc, link_status, tx_seq, rx_seq;
	logic [2:0]  tx_resend_ptr, tx_buf_ptr, retry_ptr;
	logic [1:0]  fail_code;
	int          n_mismatch = 0, n_checks = 0, cyc = 0;
	int          m_tp = 0, m_rp = 0, m_tsc = 0, m_rsc = 0, m_peer = 0, p, c, i, md;
	int          st [1:4] = '{0, 2, 3, 0};
	logic [1:0]  fc [1:4] = '{lers_pkg::FC_LINK_RESET, lers_pkg::FC_DISABLED_TMO,
		lers_pkg::FC_READY_TMO, lers_pkg::FC_INVALID_RETRY};
	logic [15:0] seed = 16'h0041;
	logic [7:0]  msk = 8'h03;

	always #4 ref_clk = ~ref_clk;

	lers_core #(.TMO_CYCLES(TMO)) u_dut (
		.REF_CLK(ref_clk), .RST(rst), .EXT_MODE(ext_mode), .TX_FRAME_START(tx_frame_start),
		.TX_BUSY(tx_busy), .RX_GOOD_FRAME(rx_good_frame), .RX_ACK(rx_ack), .RX_CODE_VIOL(rx_code_viol),
		.RX_LINK_RESET(rx_link_reset), .RX_REMOTE_RSC(rx_remote_rsc), .RX_DIS(rx_dis), .RX_FLAG(rx_flag),
		.FRAME_READY(frame_ready), .TX_ABORT(tx_abort), .TX_SEND_ACK(tx_send_ack),
		.TX_SEND_LINK_RESET(tx_send_link_reset), .LINK_STATUS(link_status), .TX_SEND_DIS(tx_send_dis),
		.TX_SEND_FLAG(tx_send_flag), .TX_RESEND(tx_resend), .TX_RESEND_PTR(tx_resend_ptr),
		.TX_BUF_PTR(tx_buf_ptr), .RETRY_PTR(retry_ptr), .TX_SEQ(tx_seq), .RX_SEQ(rx_seq),
		.ERP_ACTIVE(erp_active), .ERP_DONE(erp_done), .ERP_FAIL(erp_fail), .FAIL_CODE(fail_code));

	lers_peer u_peer (
		.clk(ref_clk), .rst(rst), .mode(mode), .drop_ack(drop_ack), .dly(dly),
		.frame_start(tx_frame_start | tx_resend), .tx_busy(tx_busy), .tx_abort(tx_abort),
		.send_lr(tx_send_link_reset), .send_dis(tx_send_dis), .send_flag(tx_send_flag),
		.rx_ack(rx_ack), .rx_link_reset(rx_link_reset), .rx_remote_rsc(rx_remote_rsc),
		.rx_dis(rx_dis), .rx_flag(rx_flag));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	function automatic logic sig(input int s);
		case (s)
			0: return tx_send_link_reset;
			1: return tx_send_ack;
			2: return tx_send_dis;
			3: return tx_send_flag;
			4: return erp_done;
			5: return tx_resend;
			6: return erp_fail;
			default: return frame_ready;
		endcase
	endfunction

	task automatic tick;
		@(posedge ref_clk);
		#1;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic wait_on(input int s, input int lim, input string what, output int n);
		n = 0;
		while (sig(s) !== 1'b1 && n < lim) begin
			tick;
			n++;
		end
		chk(what, sig(s), 1);
	endtask

	task automatic cmp;
		chk("tx_buf_ptr", tx_buf_ptr, m_tp & 7);
		chk("retry_ptr", retry_ptr, m_rp & 7);
		chk("tx_seq", tx_seq & msk, m_tsc & msk);
		chk("rx_seq", rx_seq & msk, m_rsc & msk);
	endtask

	task automatic send(input int len, input logic abort);
		wait_on(7, 20, "frame_ready", c);
		tx_frame_start = 1'b1;
		tick;
		tx_frame_start = 1'b0;
		tx_busy = 1'b1;
		m_tp++;
		m_tsc++;
		repeat (len) tick;
		if (abort) begin
			rx_code_viol = 1'b1;
			tick;
			rx_code_viol = 1'b0;
			chk("tx_abort", tx_abort, 1);
			tx_frame_start = 1'b1; // refused while checking
			tick;
			tx_frame_start = 1'b0;
			chk("erp_active", erp_active, 1);
			repeat (3) begin
				chk("early_lr", tx_send_link_reset, 0);
				tick;
			end
		end else
			m_peer++;
		tx_busy = 1'b0;
	endtask

	task automatic summarize;
		if (n_mismatch == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			summarize;
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (4) tick;
		rst = 1'b0;
		tick;
		cmp;
		for (i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			dly = seed[7:4];
			send(1 + seed[1:0], 1'b0);
			repeat (3) tick;
			m_rp++;
			if (seed[2]) begin
				rx_good_frame = 1'b1;
				tick;
				rx_good_frame = 1'b0;
				chk("ack", tx_send_ack, 1);
				m_rsc++;
			end
			cmp;
		end
		drop_ack = 1'b1;
		send(2, 1'b0);
		repeat (3) tick;
		drop_ack = 1'b0;
		send(2, 1'b1);
		wait_on(0, 5, "link_reset", c);
		chk("link_status", link_status & msk, m_rsc & msk);
		wait_on(1, 30, "lr_ack", c);
		p = (m_tsc - m_peer) & msk;
		m_tp = m_tp - p;
		m_rp = m_tp;
		m_tsc = 0;
		m_rsc = 0;
		wait_on(2, 30, "disabled", c);
		cmp;
		wait_on(3, 40, "enabled", c);
		wait_on(4, 40, "erp_done", c);
		for (i = 0; i < p; i++) begin
			wait_on(5, 20, "resend", c);
			chk("resend_ptr", tx_resend_ptr, m_tp & 7);
			tx_busy = 1'b1;
			repeat (2) tick;
			tx_busy = 1'b0;
			m_tp++;
			m_tsc++;
			m_rp++;
			repeat (3) tick;
			cmp;
		end
		for (md = 1; md <= 4; md++) begin
			rst = 1'b1;
			mode = md[2:0];
			ext_mode = md[0];
			repeat (2) tick;
			rst = 1'b0;
			repeat (2) tick;
			rx_code_viol = 1'b1;
			tick;
			rx_code_viol = 1'b0;
			wait_on(st[md], 20, "phase", c);
			wait_on(6, TMO + 40, "erp_fail", c);
			chk("tmo_len", md == 4 || (c >= TMO - 3 && c <= TMO + 3), 1);
			chk("fail_code", fail_code, fc[md]);
		end
		summarize;
	end
endmodule
`default_nettype wire
